//--- common/lad_defs.svh
// Constants for the logon and acquisition descriptor parser
`ifndef LAD_DEFS_SVH
`define LAD_DEFS_SVH

// ----------------------------------------------------------------
// Descriptor tags (plain defaults, overridable by parameter)
// ----------------------------------------------------------------
`define LAD_LOGON_TAG 8'hA1
`define LAD_ACQ_TAG 8'hA2

// ----------------------------------------------------------------
// Body sizes in bytes after the length byte
// ----------------------------------------------------------------
`define LAD_BODY_MAX 12
`define LAD_LEN_ATM_IP 8'h08
`define LAD_LEN_ATM_ATM 8'h0C
`define LAD_LEN_TS 8'h06
`define LAD_LEN_TS_LABEL 8'h08
`define LAD_LEN_ACQ 8'h0A
`define LAD_LEN_LOGON_MIN 8'h05

// ----------------------------------------------------------------
// Bit positions inside the flag bytes (body bytes 3 and 4)
// ----------------------------------------------------------------
`define LAD_BIT_HANDSHAKE 4
`define LAD_BIT_PREFIX 3
`define LAD_BIT_LABEL 2
`define LAD_BIT_MINI 1
`define LAD_BIT_CMINI 0
`define LAD_BIT_BURST 5
`define LAD_BIT_CONN 4

// ----------------------------------------------------------------
// Reset values: default signalling channel 0/5
// ----------------------------------------------------------------
`define LAD_SETUP_PATH_RST 8'h00
`define LAD_SETUP_CHAN_RST 16'h0005

`endif

//--- common/lad_pkg.sv
// Types for the logon and acquisition descriptor parser
package lad_pkg;
  typedef enum logic [1:0] {
    LAD_S_TAG = 2'b00,
    LAD_S_LEN = 2'b01,
    LAD_S_BODY = 2'b11,
    LAD_S_EVAL = 2'b10
  } lad_state_t;
endpackage

//--- core/lad_parser.sv
// Parser for the logon-initialise and acquisition-assignment descriptors
`include "lad_defs.svh"

module lad_parser #(
  parameter logic [7:0] LOGON_TAG = `LAD_LOGON_TAG,
  parameter logic [7:0] ACQ_TAG = `LAD_ACQ_TAG
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic in_valid,
  input wire logic in_first,
  input wire logic [7:0] in_data,
  input wire logic plan_acq_valid,
  input wire logic [4:0] plan_acq_frame,
  input wire logic [10:0] plan_acq_slot,
  input wire logic meas_valid,
  input wire logic [7:0] meas_time_corr,
  input wire logic [15:0] meas_freq_corr,
  output lad_pkg::lad_state_t state,
  output logic logon_done,
  output logic acq_done,
  output logic desc_error,
  output logic [7:0] terminal_group_number,
  output logic [15:0] terminal_session_number,
  output logic handshake_required,
  output logic prefix_method,
  output logic unit_labelling,
  output logic mini_slot,
  output logic contention_mini_slot,
  output logic burst_is_stream,
  output logic atm_connectivity,
  output logic [7:0] uplink_path_id,
  output logic [15:0] uplink_channel_id,
  output logic [7:0] uplink_setup_path_id,
  output logic [15:0] uplink_setup_channel_id,
  output logic [7:0] downlink_setup_path_id,
  output logic [15:0] downlink_setup_channel_id,
  output logic [12:0] uplink_payload_stream_id,
  output logic [12:0] uplink_admin_stream_id,
  output logic [7:0] coarse_timing_limit,
  output logic [15:0] coarse_freq_limit,
  output logic [5:0] coarse_burst_count,
  output logic coarse_sustained,
  output logic [15:0] coarse_first_superframe,
  output logic [4:0] coarse_frame_index,
  output logic [5:0] coarse_repeat_interval,
  output logic [10:0] coarse_slot_index,
  output logic coarse_from_plan,
  output logic ready_for_fine_sync
);
  import lad_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] lad_mag(input logic [15:0] v);
    lad_mag = v[15] ? 16'(~v + 16'h0001) : v;
  endfunction

  // Expected logon body length from the flag bytes
  function automatic logic [7:0] lad_logon_len(input logic [7:0] b3, input logic [7:0] b4);
    if (!b4[`LAD_BIT_BURST]) begin
      lad_logon_len = b4[`LAD_BIT_CONN] ? `LAD_LEN_ATM_ATM : `LAD_LEN_ATM_IP;
    end else begin
      lad_logon_len = b3[`LAD_BIT_LABEL] ? `LAD_LEN_TS_LABEL : `LAD_LEN_TS;
    end
  endfunction

  // ----------------------------------------------------------------
  // Byte collection and decode
  // ----------------------------------------------------------------
  logic [7:0] tag, next_tag;
  logic [7:0] len, next_len;
  logic [7:0] cnt, next_cnt;
  logic [7:0] body [`LAD_BODY_MAX];
  logic [7:0] next_body [`LAD_BODY_MAX];
  lad_state_t next_state;
  logic next_logon_done, next_acq_done, next_desc_error;
  logic [7:0] next_group;
  logic [15:0] next_session;
  logic [4:0] next_flags;
  logic next_stream, next_atm;
  logic [7:0] next_upath, next_uspath, next_dspath;
  logic [15:0] next_uchan, next_uschan, next_dschan;
  logic [12:0] next_pay, next_adm;
  logic [7:0] next_tlim;
  logic [15:0] next_flim, next_sf;
  logic [5:0] next_rep, next_per;
  logic [4:0] next_frame;
  logic [10:0] next_slot;
  logic next_from_plan;

  always_comb begin
    next_state = state;
    next_tag = tag;
    next_len = len;
    next_cnt = cnt;
    next_body = body;
    next_logon_done = 1'b0;
    next_acq_done = 1'b0;
    next_desc_error = 1'b0;
    next_group = terminal_group_number;
    next_session = terminal_session_number;
    next_flags = {handshake_required, prefix_method, unit_labelling, mini_slot,
                  contention_mini_slot};
    next_stream = burst_is_stream;
    next_atm = atm_connectivity;
    next_upath = uplink_path_id;
    next_uchan = uplink_channel_id;
    next_uspath = uplink_setup_path_id;
    next_uschan = uplink_setup_channel_id;
    next_dspath = downlink_setup_path_id;
    next_dschan = downlink_setup_channel_id;
    next_pay = uplink_payload_stream_id;
    next_adm = uplink_admin_stream_id;
    next_tlim = coarse_timing_limit;
    next_flim = coarse_freq_limit;
    next_rep = coarse_burst_count;
    next_sf = coarse_first_superframe;
    next_frame = coarse_frame_index;
    next_per = coarse_repeat_interval;
    next_slot = coarse_slot_index;
    next_from_plan = coarse_from_plan;
    if (plan_acq_valid) begin
      next_frame = plan_acq_frame;
      next_slot = plan_acq_slot;
      next_from_plan = 1'b1;
    end
    if (state == LAD_S_EVAL) begin
      // Reserved bits are simply never selected below
      if (tag == LOGON_TAG) begin
        if (len < `LAD_LEN_LOGON_MIN || len != lad_logon_len(body[3], body[4])) begin
          next_desc_error = 1'b1;
        end else begin
          next_logon_done = 1'b1;
          next_group = body[0];
          next_session = {body[1], body[2]};
          next_flags = body[3][`LAD_BIT_HANDSHAKE:`LAD_BIT_CMINI];
          next_stream = body[4][`LAD_BIT_BURST];
          if (!body[4][`LAD_BIT_BURST]) begin
            next_atm = body[4][`LAD_BIT_CONN];
            if (!body[4][`LAD_BIT_CONN]) begin
              next_upath = body[5];
              next_uchan = {body[6], body[7]};
            end else begin
              next_uspath = body[5];
              next_uschan = {body[6], body[7]};
              next_dspath = body[9];
              next_dschan = {body[10], body[11]};
            end
          end else begin
            next_atm = 1'b0;
            next_pay = {body[4][4:0], body[5]};
            if (body[3][`LAD_BIT_LABEL]) begin
              next_adm = {body[6][4:0], body[7]};
            end
          end
        end
      end else if (tag == ACQ_TAG) begin
        if (len != `LAD_LEN_ACQ) begin
          next_desc_error = 1'b1;
        end else begin
          next_acq_done = 1'b1;
          next_tlim = body[0];
          next_flim = {body[1], body[2]};
          next_rep = body[3][5:0];
          next_sf = {body[4], body[5]};
          next_frame = body[6][4:0];
          next_per = body[7][5:0];
          next_slot = {body[8][2:0], body[9]};
          next_from_plan = 1'b0;
        end
      end
    end
    case (state)
      LAD_S_TAG, LAD_S_EVAL: begin
        next_state = LAD_S_TAG;
        if (in_valid) begin
          next_tag = in_data;
          next_state = LAD_S_LEN;
        end
      end
      LAD_S_LEN: begin
        if (in_valid) begin
          next_len = in_data;
          next_cnt = 8'h00;
          next_state = (in_data == 8'h00) ? LAD_S_EVAL : LAD_S_BODY;
        end
      end
      LAD_S_BODY: begin
        if (in_valid) begin
          // Bytes past the longest layout are counted but not kept
          if (cnt < 8'(`LAD_BODY_MAX)) begin
            next_body[cnt[3:0]] = in_data;
          end
          next_cnt = 8'(cnt + 8'h01);
          if (8'(cnt + 8'h01) == len) begin
            next_state = LAD_S_EVAL;
          end
        end
      end
      default: next_state = LAD_S_TAG;
    endcase
    // A marked first byte resynchronises even mid-descriptor
    if (in_valid && in_first) begin
      next_tag = in_data;
      next_state = LAD_S_LEN;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      state <= LAD_S_TAG;
      tag <= 8'h00;
      len <= 8'h00;
      cnt <= 8'h00;
      for (int i = 0; i < `LAD_BODY_MAX; i++) begin
        body[i] <= 8'h00;
      end
      logon_done <= 1'b0;
      acq_done <= 1'b0;
      desc_error <= 1'b0;
      terminal_group_number <= 8'h00;
      terminal_session_number <= 16'h0000;
      {handshake_required, prefix_method, unit_labelling, mini_slot,
       contention_mini_slot} <= 5'h00;
      burst_is_stream <= 1'b0;
      atm_connectivity <= 1'b0;
      uplink_path_id <= 8'h00;
      uplink_channel_id <= 16'h0000;
      uplink_setup_path_id <= `LAD_SETUP_PATH_RST;
      uplink_setup_channel_id <= `LAD_SETUP_CHAN_RST;
      downlink_setup_path_id <= `LAD_SETUP_PATH_RST;
      downlink_setup_channel_id <= `LAD_SETUP_CHAN_RST;
      uplink_payload_stream_id <= 13'h0000;
      uplink_admin_stream_id <= 13'h0000;
      coarse_timing_limit <= 8'h00;
      coarse_freq_limit <= 16'h0000;
      coarse_burst_count <= 6'h00;
      coarse_first_superframe <= 16'h0000;
      coarse_frame_index <= 5'h00;
      coarse_repeat_interval <= 6'h00;
      coarse_slot_index <= 11'h000;
      coarse_from_plan <= 1'b0;
    end else begin
      state <= next_state;
      tag <= next_tag;
      len <= next_len;
      cnt <= next_cnt;
      body <= next_body;
      logon_done <= next_logon_done;
      acq_done <= next_acq_done;
      desc_error <= next_desc_error;
      terminal_group_number <= next_group;
      terminal_session_number <= next_session;
      {handshake_required, prefix_method, unit_labelling, mini_slot,
       contention_mini_slot} <= next_flags;
      burst_is_stream <= next_stream;
      atm_connectivity <= next_atm;
      uplink_path_id <= next_upath;
      uplink_channel_id <= next_uchan;
      uplink_setup_path_id <= next_uspath;
      uplink_setup_channel_id <= next_uschan;
      downlink_setup_path_id <= next_dspath;
      downlink_setup_channel_id <= next_dschan;
      uplink_payload_stream_id <= next_pay;
      uplink_admin_stream_id <= next_adm;
      coarse_timing_limit <= next_tlim;
      coarse_freq_limit <= next_flim;
      coarse_burst_count <= next_rep;
      coarse_first_superframe <= next_sf;
      coarse_frame_index <= next_frame;
      coarse_repeat_interval <= next_per;
      coarse_slot_index <= next_slot;
      coarse_from_plan <= next_from_plan;
    end
  end

  // ----------------------------------------------------------------
  // Coarse-sync exit test
  // ----------------------------------------------------------------
  logic time_ok, freq_ok, next_ready;

  // All-zero count is a standing burst, not zero repeats
  assign coarse_sustained = (coarse_burst_count == 6'h00);

  always_comb begin
    // Same scale as the timing correction, so no shift here
    time_ok = lad_mag({{8{meas_time_corr[7]}}, meas_time_corr})
              <= {8'h00, coarse_timing_limit};
    freq_ok = lad_mag(meas_freq_corr) <= coarse_freq_limit;
    next_ready = ready_for_fine_sync;
    if (meas_valid) begin
      if (coarse_timing_limit != 8'h00 && coarse_freq_limit != 16'h0000) begin
        next_ready = time_ok && freq_ok;
      end else if (coarse_timing_limit != 8'h00) begin
        next_ready = time_ok;
      end else if (coarse_freq_limit != 16'h0000) begin
        next_ready = freq_ok;
      end else begin
        next_ready = time_ok && freq_ok;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      ready_for_fine_sync <= 1'b0;
    end else begin
      ready_for_fine_sync <= next_ready;
    end
  end
endmodule // lad_parser

//--- test/lad_ncc_model.sv
// Behavioural control-centre sender feeding descriptor bytes
module lad_ncc_model (
  input wire logic mclk,
  input wire logic srst,
  input wire logic go,
  input wire logic slow,
  input wire logic [4:0] count,
  input wire logic [111:0] msg,
  output logic in_valid = 1'b0,
  output logic in_first = 1'b0,
  output logic [7:0] in_data = 8'h00,
  output logic busy = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] idx;
  logic gap;
  // ------------------------------------------------
  // Byte stream, optionally with idle gaps
  // ------------------------------------------------
  // Idle data flips every cycle so a stale byte never looks valid
  always_ff @(posedge mclk) begin
    in_valid <= 1'b0;
    in_first <= 1'b0;
    in_data <= ~in_data;
    gap <= 1'b0;
    if (srst) begin
      busy <= 1'b0;
      in_data <= 8'h00;
    end else if (!busy) begin
      busy <= go;
      idx <= 5'h00;
    end else if (idx == count) begin
      busy <= 1'b0;
    end else if (!gap) begin
      in_valid <= 1'b1;
      in_first <= idx == 5'h00;
      in_data <= msg[8 * (5'd13 - idx) +: 8];
      idx <= idx + 5'h01;
      gap <= slow;
    end
  end
endmodule // lad_ncc_model

//--- test/lad_parser_bench.sv
// Self-checking bench for the descriptor parser
`include "lad_defs.svh"
`define CHK(nm, ex, gt) begin checks_done++; if ((gt) !== (ex)) begin bad_count++; \
  $display("[ERR] %s exp %0h got %0h", nm, ex, gt); end end
module lad_parser_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import lad_pkg::*;
  logic mclk = 1'b0, srst = 1'b1, go = 1'b0, slow = 1'b0, plan_acq_valid = 1'b0;
  logic meas_valid = 1'b0, in_valid, in_first, busy;
  logic [7:0] in_data, meas_time_corr = 8'h00, last_g = 8'h00;
  logic [15:0] meas_freq_corr = 16'h0000;
  logic [4:0] count = 5'h00, plan_acq_frame = 5'h00, coarse_frame_index;
  logic [10:0] plan_acq_slot = 11'h000, coarse_slot_index;
  logic [111:0] msg = '0;
  logic [31:0] seed = 32'h4A1F;
  lad_state_t state;
  logic logon_done, acq_done, desc_error, handshake_required, prefix_method, unit_labelling;
  logic mini_slot, contention_mini_slot, burst_is_stream, atm_connectivity;
  logic coarse_sustained, coarse_from_plan, ready_for_fine_sync;
  logic [7:0] terminal_group_number, uplink_path_id, uplink_setup_path_id;
  logic [7:0] downlink_setup_path_id, coarse_timing_limit;
  logic [15:0] terminal_session_number, uplink_channel_id, uplink_setup_channel_id;
  logic [15:0] downlink_setup_channel_id, coarse_freq_limit, coarse_first_superframe;
  logic [12:0] uplink_payload_stream_id, uplink_admin_stream_id;
  logic [5:0] coarse_burst_count, coarse_repeat_interval;
  int bad_count = 0, checks_done = 0;
  wire [4:0] flag_bits = {handshake_required, prefix_method, unit_labelling, mini_slot,
    contention_mini_slot};
  wire [47:0] setup_bits = {uplink_setup_path_id, uplink_setup_channel_id,
    downlink_setup_path_id, downlink_setup_channel_id};

  lad_parser dut_u (.mclk, .srst, .in_valid, .in_first, .in_data, .plan_acq_valid,
    .plan_acq_frame, .plan_acq_slot, .meas_valid, .meas_time_corr, .meas_freq_corr, .state,
    .logon_done, .acq_done, .desc_error, .terminal_group_number, .terminal_session_number,
    .handshake_required, .prefix_method, .unit_labelling, .mini_slot, .contention_mini_slot,
    .burst_is_stream, .atm_connectivity, .uplink_path_id, .uplink_channel_id,
    .uplink_setup_path_id, .uplink_setup_channel_id, .downlink_setup_path_id,
    .downlink_setup_channel_id, .uplink_payload_stream_id, .uplink_admin_stream_id,
    .coarse_timing_limit, .coarse_freq_limit, .coarse_burst_count, .coarse_sustained,
    .coarse_first_superframe, .coarse_frame_index, .coarse_repeat_interval,
    .coarse_slot_index, .coarse_from_plan, .ready_for_fine_sync);
  lad_ncc_model ncc_u (.mclk, .srst, .go, .slow, .count, .msg, .in_valid, .in_first,
    .in_data, .busy);

  // ------------------------------------------------
  // Helpers
  // ------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Magnitude test; -128 counts as 128
  function automatic logic fine(logic [7:0] tl, logic [15:0] fr, logic [7:0] t, logic [15:0] q);
    logic ok_t, ok_f;
    ok_t = (t[7] ? 9'h100 - t : {1'b0, t}) <= {1'b0, tl};
    ok_f = (q[15] ? 17'h10000 - q : {1'b0, q}) <= {1'b0, fr};
    return (tl == 0 && fr != 0 || ok_t) && (fr == 0 && tl != 0 || ok_f);
  endfunction

  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic send(input logic [111:0] m, input int n, output logic [2:0] f);
    @(posedge mclk);
    msg <= m << (8 * (14 - n));
    count <= 5'(n);
    slow <= 1'(rnd());
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    f = 3'b000;
    for (int i = 0; i < 60 && f == 3'b000; i++) begin
      @(posedge mclk);
      #1;
      f = {logon_done, acq_done, desc_error};
    end
    if (f == 3'b000) begin
      bad_count++;
      stop_test();
    end
  endtask

  task automatic logon(input int k, input logic e);
    logic [7:0] g, p, q;
    logic [15:0] s, c, d;
    logic [12:0] t, a;
    logic [4:0] fl;
    logic [31:0] r;
    logic [111:0] m;
    logic [2:0] f;
    int n;
    {g, s, p} = rnd();
    {c, d} = rnd();
    {t, a, fl} = 31'(rnd());
    r = rnd();
    q = r[31:24];
    if (k > 1) fl[2] = k == 3;
    // Reserved bits are random, as an encrypting sender fills them
    case (k)
      0: m = {g, s, r[2:0], fl, r[4:3], 2'b00, r[8:5], p, c};
      1: m = {g, s, r[2:0], fl, r[4:3], 2'b01, r[8:5], p, c, r[23:16], q, d};
      default: m = {g, s, r[2:0], fl, r[4:3], 1'b1, t, r[7:5], a};
    endcase
    n = (k == 1) ? 12 : (k == 2) ? 6 : 8;
    if (k == 2) m = m >> 16;
    if (e) begin
      m = {m[103:0], q};
      n++;
    end
    m |= 112'({`LAD_LOGON_TAG, 8'(n)}) << (8 * n);
    send(m, n + 2, f);
    `CHK("result", e ? 3'b001 : 3'b100, f)
    if (e) begin
      `CHK("kept", last_g, terminal_group_number)
      return;
    end
    last_g = g;
    `CHK("group", g, terminal_group_number)
    `CHK("session", s, terminal_session_number)
    `CHK("flags", fl, flag_bits)
    `CHK("burst", k > 1, burst_is_stream)
    `CHK("conn", k == 1, atm_connectivity)
    case (k)
      0: `CHK("path", {p, c}, {uplink_path_id, uplink_channel_id})
      1: `CHK("setup", {p, c, q, d}, setup_bits)
      default: `CHK("payload", t, uplink_payload_stream_id)
    endcase
    if (k == 3) `CHK("admin", a, uplink_admin_stream_id)
  endtask

  task automatic coarse(input logic zero);
    logic [7:0] tl;
    logic [15:0] fr, sf;
    logic [5:0] rc, rp;
    logic [4:0] fi;
    logic [10:0] sl;
    logic [31:0] r;
    logic [2:0] f;
    {tl, fr, rc} = 30'(rnd());
    {sf, fi, sl} = rnd();
    r = rnd();
    rp = r[31:26];
    if (zero) {rc, tl} = 14'h0000;
    send({`LAD_ACQ_TAG, `LAD_LEN_ACQ, tl, fr, r[1:0], rc, sf, r[4:2], fi, r[6:5], rp, r[11:7],
      sl}, 12, f);
    `CHK("result", 3'b010, f)
    `CHK("coarse", {tl, fr, rc, sf, fi, rp, sl}, {coarse_timing_limit, coarse_freq_limit,
      coarse_burst_count, coarse_first_superframe, coarse_frame_index, coarse_repeat_interval,
      coarse_slot_index})
    `CHK("sustained", rc == 6'h00, coarse_sustained)
    repeat (4) begin
      r = rnd();
      @(posedge mclk);
      meas_valid <= 1'b1;
      meas_time_corr <= r[7:0];
      meas_freq_corr <= {{8{r[15]}}, r[15:8]};
      @(posedge mclk);
      meas_valid <= 1'b0;
      #1;
      `CHK("fine", fine(tl, fr, r[7:0], {{8{r[15]}}, r[15:8]}), ready_for_fine_sync)
    end
    @(posedge mclk);
    plan_acq_valid <= 1'b1;
    plan_acq_frame <= r[20:16];
    plan_acq_slot <= r[31:21];
    @(posedge mclk);
    plan_acq_valid <= 1'b0;
    #1;
    `CHK("plan", {1'b1, r[20:16], r[31:21]}, {coarse_from_plan, coarse_frame_index,
      coarse_slot_index})
  endtask

  // ------------------------------------------------
  // Main sequence
  // ------------------------------------------------
  initial begin
    forever #25 mclk = ~mclk;
  end

  initial begin
    int k;
    repeat (8) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    #1;
    `CHK("setup", {8'h00, 16'h0005, 8'h00, 16'h0005}, setup_bits)
    `CHK("sustained", 1'b1, coarse_sustained)
    coarse(1'b1);
    for (int i = 0; i < 30; i++) begin
      k = (i < 6) ? i : int'(rnd() % 6);
      // Bad length never uses the 12-byte layout: one extra byte would overflow msg
      if (k == 4) coarse(1'b0);
      else logon((k == 5) ? 2 * int'(rnd() % 2) : k, k == 5);
    end
    stop_test();
  end
endmodule // lad_parser_bench

//--- test/lad_properties.sv
// Concurrent checks on the descriptor parser ports
module lad_parser_checker
  import lad_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic in_valid,
  input wire logic in_first,
  input wire logic plan_acq_valid,
  input wire logic [10:0] plan_acq_slot,
  input wire logic meas_valid,
  input wire lad_pkg::lad_state_t state,
  input wire logic logon_done,
  input wire logic acq_done,
  input wire logic desc_error,
  input wire logic [7:0] terminal_group_number,
  input wire logic [15:0] terminal_session_number,
  input wire logic burst_is_stream,
  input wire logic atm_connectivity,
  input wire logic [15:0] uplink_setup_channel_id,
  input wire logic [5:0] coarse_burst_count,
  input wire logic coarse_sustained,
  input wire logic coarse_from_plan,
  input wire logic [10:0] coarse_slot_index,
  input wire logic ready_for_fine_sync
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);
  // ------------------------------------------------
  // Byte roles, completion pulses and field updates
  // ------------------------------------------------
  sequence tag_byte;
    in_valid && (in_first || state == LAD_S_TAG || state == LAD_S_EVAL);
  endsequence
  tag_len_a: assert property (tag_byte |=> state == LAD_S_LEN)
    else $error("tag byte not followed by length");
  done_onehot_a: assert property ($onehot0({logon_done, acq_done, desc_error}))
    else $error("two completion pulses at once");
  logon_pulse_a: assert property (logon_done |-> $past(state) == LAD_S_EVAL ##1 !logon_done)
    else $error("logon pulse misplaced");
  acq_pulse_a: assert property (acq_done |=> !acq_done)
    else $error("coarse pulse too long");
  stream_ip_a: assert property (burst_is_stream |-> !atm_connectivity)
    else $error("stream bursts with cell connectivity");
  sustained_a: assert property (coarse_sustained == (coarse_burst_count == 6'h00))
    else $error("sustained flag wrong");
  error_keep_a: assert property (desc_error |-> $stable(terminal_group_number)
    && $stable(terminal_session_number))
    else $error("fields changed on bad length");
  plan_load_a: assert property (plan_acq_valid |=> acq_done
    || coarse_from_plan && coarse_slot_index == $past(plan_acq_slot))
    else $error("plan slot not loaded");
  fine_hold_a: assert property (!$past(meas_valid) && !$past(srst)
    |-> $stable(ready_for_fine_sync))
    else $error("fine sync moved without measurement");
  setup_only_a: assert property ($changed(uplink_setup_channel_id) && !$past(srst)
    |-> logon_done && atm_connectivity)
    else $error("setup channel changed outside cell logon");
endmodule // lad_parser_checker

bind lad_parser lad_parser_checker chk_u (.mclk, .srst, .in_valid, .in_first, .plan_acq_valid,
  .plan_acq_slot, .meas_valid, .state, .logon_done, .acq_done, .desc_error,
  .terminal_group_number, .terminal_session_number, .burst_is_stream, .atm_connectivity,
  .uplink_setup_channel_id, .coarse_burst_count, .coarse_sustained, .coarse_from_plan,
  .coarse_slot_index, .ready_for_fine_sync);
